// File: rtl/rsu_settings.sv
// rsu_settings: applies bytes 5..8 of a run-time settings command.
// assumes command bytes are written into the slave before the execute write.
// Summary of operation
// - byte 5 bit 7 loads converter reference
// - bits 2-1 choose internal reference level
// - bit 0 picks internal module or supply
// - byte 6 bit 7 gates interrupt changes
// - bit 4 enables rising-edge update from bit 3
// - bit 2 enables falling-edge update from bit 1
// - bit 0 clears the interrupt flag
// - byte 7 bit 7 loads pin settings
// - byte 8 bits 2-0 pick pin function
// - bit 3 direction, only in general I/O
// - output pin drives bit 4 value
// - code 0x60 in byte 0 runs command
// - settings volatile, lost only at reset
// - response echoes 0x60 then 0x00
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rsu_settings #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // converter reference
  output rsu_pkg::rsu_adc_ref_t adc_ref,
  // interrupt detection
  input wire logic int_detect_in,
  output logic int_flag,
  // general_pin_zero
  input wire logic general_pin_zero_in,
  output logic general_pin_zero_out,
  output logic general_pin_zero_oe,
  input wire logic suspend_indicator,
  input wire logic uart_receive_led
);
  import rsu_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ADDR_W < 8) begin : g_addr_chk
    $error("rsu_settings: ADDR_W must be at least 8");
  end
  if (DATA_W < 32) begin : g_data_chk
    $error("rsu_settings: DATA_W must be at least 32");
  end

  // the slices below assume this map; a bad edit of the package stops here
  if (RSU_IDX_CODE != 0) begin : g_code_chk
    $error("rsu_settings: command code must sit in byte 0");
  end

  if (RSU_IDX_ADC >= RSU_NUM_CMD_BYTES || RSU_IDX_INT >= RSU_NUM_CMD_BYTES ||
      RSU_IDX_GPALT >= RSU_NUM_CMD_BYTES || RSU_IDX_GP0 >= RSU_NUM_CMD_BYTES) begin : g_idx_chk
    $error("rsu_settings: byte index outside the command buffer");
  end

  if (int'(RSU_OFS_CMD_BASE) + 4 * (RSU_NUM_CMD_BYTES - 1) >=
      int'(RSU_OFS_EXEC)) begin : g_map_chk
    $error("rsu_settings: command bytes run into the execute word");
  end

  if (RSU_OFS_EXEC == RSU_OFS_RESP || RSU_OFS_EXEC == RSU_OFS_STATUS ||
      RSU_OFS_RESP == RSU_OFS_STATUS) begin : g_ctl_chk
    $error("rsu_settings: control words share an offset");
  end

  if (RSU_OFS_CMD_BASE[1:0] != 2'h0 || RSU_OFS_EXEC[1:0] != 2'h0 ||
      RSU_OFS_RESP[1:0] != 2'h0 || RSU_OFS_STATUS[1:0] != 2'h0) begin : g_align_chk
    $error("rsu_settings: register offsets must be word aligned");
  end

  if (RSU_ADC_LVL_HI - RSU_ADC_LVL_LO != 1) begin : g_lvl_chk
    $error("rsu_settings: reference level field must be two bits");
  end

  if (RSU_GP_FN_HI - RSU_GP_FN_LO != 2) begin : g_fn_chk
    $error("rsu_settings: pin function field must be three bits");
  end

  if (RSU_ADC_LOAD_BIT > 7 || RSU_ADC_SRC_BIT > 7 || RSU_INT_MOD_BIT > 7 ||
      RSU_INT_POS_MOD_BIT > 7 || RSU_INT_POS_VAL_BIT > 7 || RSU_INT_NEG_MOD_BIT > 7 ||
      RSU_INT_NEG_VAL_BIT > 7 || RSU_GPALT_BIT > 7 || RSU_GP_VAL_BIT > 7 ||
      RSU_GP_DIR_BIT > 7 || RSU_GP_FN_HI > 7) begin : g_bit_chk
    $error("rsu_settings: a field lies outside its byte");
  end

  // ************************************************************
  // command byte buffer
  // ************************************************************
  logic [7:0] cmd_reg [RSU_NUM_CMD_BYTES];
  logic [ADDR_W-1:0] ofs_exec;
  logic [ADDR_W-1:0] ofs_resp;
  logic [ADDR_W-1:0] ofs_status;
  logic exec_hit;
  logic run;

  assign ofs_exec = ADDR_W'(RSU_OFS_EXEC);
  assign ofs_resp = ADDR_W'(RSU_OFS_RESP);
  assign ofs_status = ADDR_W'(RSU_OFS_STATUS);

  for (genvar i = 0; i < RSU_NUM_CMD_BYTES; i++) begin : g_cmd
    logic [ADDR_W-1:0] ofs;
    assign ofs = ADDR_W'(RSU_OFS_CMD_BASE) + ADDR_W'(4 * i);
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        cmd_reg[i] <= 8'h00;
      end else if (reg_wr && reg_addr == ofs) begin
        cmd_reg[i] <= reg_wdata[7:0];
      end
    end
  end

  assign exec_hit = reg_wr && (reg_addr == ofs_exec);
  // foreign codes are ignored so stray writes cannot alter settings
  assign run = exec_hit && (cmd_reg[RSU_IDX_CODE] == RSU_CMD_CODE);

  // ************************************************************
  // converter reference
  // ************************************************************
  logic [7:0] adc_byte;
  rsu_adc_ref_t adc_ref_reg;

  assign adc_byte = cmd_reg[RSU_IDX_ADC];

  // volatile only: reset returns power-up defaults
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      adc_ref_reg.level <= rsu_vref_level_t'(RSU_RST_ADC_LVL);
      adc_ref_reg.internal_src <= RSU_RST_ADC_SRC;
    end else if (run && adc_byte[RSU_ADC_LOAD_BIT]) begin
      adc_ref_reg.level <= rsu_vref_level_t'(adc_byte[RSU_ADC_LVL_HI:RSU_ADC_LVL_LO]);
      adc_ref_reg.internal_src <= adc_byte[RSU_ADC_SRC_BIT];
    end
  end

  assign adc_ref = adc_ref_reg;

  // ************************************************************
  // interrupt detection settings
  // ************************************************************
  logic [7:0] int_byte;
  logic int_mod;
  rsu_edge_cfg_t edge_cfg_reg;
  logic flag_clear;

  assign int_byte = cmd_reg[RSU_IDX_INT];
  assign int_mod = run && int_byte[RSU_INT_MOD_BIT];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      edge_cfg_reg.pos_en <= RSU_RST_POS_EN;
    end else if (int_mod && int_byte[RSU_INT_POS_MOD_BIT]) begin
      edge_cfg_reg.pos_en <= int_byte[RSU_INT_POS_VAL_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      edge_cfg_reg.neg_en <= RSU_RST_NEG_EN;
    end else if (int_mod && int_byte[RSU_INT_NEG_MOD_BIT]) begin
      edge_cfg_reg.neg_en <= int_byte[RSU_INT_NEG_VAL_BIT];
    end
  end

  assign flag_clear = int_mod && int_byte[RSU_INT_CLR_BIT];

  rsu_edge_flag u_edge_flag (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .detect_in(int_detect_in),
    .edge_cfg(edge_cfg_reg),
    .clear(flag_clear),
    .flag(int_flag)
  );

  // ************************************************************
  // general_pin_zero configuration
  // ************************************************************
  logic [7:0] gp_byte;
  logic gp_load;
  logic [2:0] gp_fn_code;
  logic gp_fn_known;
  rsu_gp_cfg_t gp_cfg_reg;

  assign gp_byte = cmd_reg[RSU_IDX_GP0];
  assign gp_load = run && cmd_reg[RSU_IDX_GPALT][RSU_GPALT_BIT];
  assign gp_fn_code = gp_byte[RSU_GP_FN_HI:RSU_GP_FN_LO];
  always_comb begin
    gp_fn_known = 1'b0;
    case (gp_fn_code)
      RSU_FN_GPIO, RSU_FN_SUSPEND, RSU_FN_RX_LED: begin
        gp_fn_known = 1'b1;
      end
      default: begin
        gp_fn_known = 1'b0;
      end
    endcase
  end

  // unknown function codes keep the old function; value and direction still load
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gp_cfg_reg.fn <= RSU_FN_GPIO;
    end else if (gp_load && gp_fn_known) begin
      gp_cfg_reg.fn <= rsu_gp_fn_t'(gp_fn_code);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gp_cfg_reg.dir_in <= RSU_RST_GP_DIR;
      gp_cfg_reg.out_value <= RSU_RST_GP_VAL;
    end else if (gp_load) begin
      gp_cfg_reg.dir_in <= gp_byte[RSU_GP_DIR_BIT];
      gp_cfg_reg.out_value <= gp_byte[RSU_GP_VAL_BIT];
    end
  end

  // pin driver: direction matters only in general I/O
  always_comb begin
    general_pin_zero_out = 1'b0;
    general_pin_zero_oe = 1'b0;
    case (gp_cfg_reg.fn)
      RSU_FN_GPIO: begin
        general_pin_zero_oe = ~gp_cfg_reg.dir_in;
        general_pin_zero_out = gp_cfg_reg.out_value;
      end
      RSU_FN_SUSPEND: begin
        general_pin_zero_oe = 1'b1;
        general_pin_zero_out = suspend_indicator;
      end
      RSU_FN_RX_LED: begin
        general_pin_zero_oe = 1'b1;
        general_pin_zero_out = uart_receive_led;
      end
      default: begin
        general_pin_zero_oe = 1'b0;
        general_pin_zero_out = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // response
  // ************************************************************
  logic [7:0] resp_code_reg;
  logic [7:0] resp_status_reg;
  logic resp_ready_reg;
  logic resp_read;

  assign resp_read = reg_rd && (reg_addr == ofs_resp);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      resp_code_reg <= 8'h00;
      resp_status_reg <= 8'h00;
    end else if (run) begin
      resp_code_reg <= RSU_CMD_CODE;
      resp_status_reg <= RSU_RESP_OK;
    end
  end

  // a completion in the reading cycle is kept
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      resp_ready_reg <= 1'b0;
    end else if (run) begin
      resp_ready_reg <= 1'b1;
    end else if (resp_read) begin
      resp_ready_reg <= 1'b0;
    end
  end

  // ************************************************************
  // status and response words
  // ************************************************************
  logic [11:0] status_word;
  logic [16:0] resp_word;

  // bit 0 is the reference source, bit 11 the live pin level
  assign status_word[2:0] = adc_ref_reg;
  assign status_word[3] = edge_cfg_reg.neg_en;
  assign status_word[4] = edge_cfg_reg.pos_en;
  assign status_word[5] = int_flag;
  assign status_word[10:6] = gp_cfg_reg;
  assign status_word[11] = general_pin_zero_in;
  assign resp_word = {resp_ready_reg, resp_status_reg, resp_code_reg};

  // ************************************************************
  // read path
  // ************************************************************
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_reg;
  logic [7:0] cmd_rd;
  logic cmd_rd_hit;

  always_comb begin
    cmd_rd = 8'h00;
    cmd_rd_hit = 1'b0;
    for (int i = 0; i < RSU_NUM_CMD_BYTES; i++) begin
      if (reg_addr == ADDR_W'(RSU_OFS_CMD_BASE) + ADDR_W'(4 * i)) begin
        cmd_rd = cmd_reg[i];
        cmd_rd_hit = 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    if (cmd_rd_hit) begin
      rd_mux = DATA_W'(cmd_rd);
    end else if (reg_addr == ofs_resp) begin
      rd_mux = DATA_W'(resp_word);
    end else if (reg_addr == ofs_status) begin
      rd_mux = DATA_W'(status_word);
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : rsu_settings
`default_nettype wire

// File: rtl/rsu_pkg.sv
// rsu_pkg: constants and types for the run-time settings update block.
// assumes a single clock domain; offsets are byte addresses of 32-bit words.
package rsu_pkg;

  // ************************************************************
  // command layout
  // ************************************************************
  localparam logic [7:0] RSU_CMD_CODE = 8'h60;
  localparam logic [7:0] RSU_RESP_OK = 8'h00;
  localparam int RSU_NUM_CMD_BYTES = 9;
  localparam int RSU_IDX_CODE = 0;
  localparam int RSU_IDX_ADC = 5;
  localparam int RSU_IDX_INT = 6;
  localparam int RSU_IDX_GPALT = 7;
  localparam int RSU_IDX_GP0 = 8;

  // byte 5 fields
  localparam int RSU_ADC_LOAD_BIT = 7;
  localparam int RSU_ADC_LVL_HI = 2;
  localparam int RSU_ADC_LVL_LO = 1;
  localparam int RSU_ADC_SRC_BIT = 0;
  // byte 6 fields
  localparam int RSU_INT_MOD_BIT = 7;
  localparam int RSU_INT_POS_MOD_BIT = 4;
  localparam int RSU_INT_POS_VAL_BIT = 3;
  localparam int RSU_INT_NEG_MOD_BIT = 2;
  localparam int RSU_INT_NEG_VAL_BIT = 1;
  localparam int RSU_INT_CLR_BIT = 0;
  // byte 7 field
  localparam int RSU_GPALT_BIT = 7;
  // byte 8 fields
  localparam int RSU_GP_VAL_BIT = 4;
  localparam int RSU_GP_DIR_BIT = 3;
  localparam int RSU_GP_FN_HI = 2;
  localparam int RSU_GP_FN_LO = 0;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] RSU_OFS_CMD_BASE = 8'h00; // bytes 0..8 at 0x00..0x20
  localparam logic [7:0] RSU_OFS_EXEC = 8'h40;
  localparam logic [7:0] RSU_OFS_RESP = 8'h44;
  localparam logic [7:0] RSU_OFS_STATUS = 8'h48;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0] RSU_RST_ADC_LVL = 2'h0;
  localparam logic RSU_RST_ADC_SRC = 1'b0;
  localparam logic RSU_RST_POS_EN = 1'b0;
  localparam logic RSU_RST_NEG_EN = 1'b0;
  localparam logic RSU_RST_GP_DIR = 1'b1;
  localparam logic RSU_RST_GP_VAL = 1'b0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    RSU_VREF_OFF = 2'h0,
    RSU_VREF_1V024 = 2'h1,
    RSU_VREF_2V048 = 2'h2,
    RSU_VREF_4V096 = 2'h3
  } rsu_vref_level_t;

  typedef enum logic [2:0] {
    RSU_FN_GPIO = 3'h0,
    RSU_FN_SUSPEND = 3'h1,
    RSU_FN_RX_LED = 3'h2
  } rsu_gp_fn_t;

  typedef struct packed {
    rsu_vref_level_t level;
    logic internal_src;
  } rsu_adc_ref_t;

  typedef struct packed {
    logic out_value;
    logic dir_in;
    rsu_gp_fn_t fn;
  } rsu_gp_cfg_t;

  typedef struct packed {
    logic pos_en;
    logic neg_en;
  } rsu_edge_cfg_t;

endpackage : rsu_pkg

// File: rtl/rsu_edge_flag.sv
// rsu_edge_flag: sticky edge detector for the interrupt detection input.
// assumes the detect input is already synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module rsu_edge_flag (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // detection
  input wire logic detect_in,
  input wire rsu_pkg::rsu_edge_cfg_t edge_cfg,
  input wire logic clear,
  output logic flag
);
  import rsu_pkg::*;

  logic prev_reg;
  logic flag_reg;
  logic hit;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= detect_in;
    end
  end

  assign hit = (edge_cfg.pos_en & detect_in & ~prev_reg) |
               (edge_cfg.neg_en & ~detect_in & prev_reg);

  // set beats clear so an edge in the clearing cycle is kept
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else if (hit) begin
      flag_reg <= 1'b1;
    end else if (clear) begin
      flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;

endmodule : rsu_edge_flag
`default_nettype wire

// File: sim/rsu_settings_monitor.sv
// rsu_settings_monitor: port assertions for rsu_settings.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module rsu_settings_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // settings and pins
  input wire rsu_pkg::rsu_adc_ref_t adc_ref,
  input wire logic int_detect_in,
  input wire logic int_flag,
  input wire logic general_pin_zero_in,
  input wire logic general_pin_zero_out,
  input wire logic general_pin_zero_oe,
  input wire logic suspend_indicator,
  input wire logic uart_receive_led
);
  import rsu_pkg::*;
  // ****
  // checks
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic ex;
  assign ex = reg_wr && reg_addr == RSU_OFS_EXEC;
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_resp_fields: assert property (reg_rd && reg_addr == RSU_OFS_RESP |=>
    reg_rdata[15:8] == RSU_RESP_OK && reg_rdata[31:17] == 15'h0)
    else $error("response word malformed");
  a_status_live: assert property (reg_rd && reg_addr == RSU_OFS_STATUS |=>
    reg_rdata[2:0] == $past(adc_ref) && reg_rdata[5] == $past(int_flag)
    && reg_rdata[11] == $past(general_pin_zero_in))
    else $error("status disagrees with outputs");
  a_adc_hold: assert property ($changed(adc_ref) |-> $past(ex) || $past(ex, 2))
    else $error("reference changed without execute");
  a_oe_hold: assert property ($changed(general_pin_zero_oe) |-> $past(ex) || $past(ex, 2))
    else $error("pin enable changed without execute");
  a_flag_rise: assert property ($rose(int_flag) |->
    $past(int_detect_in) != $past(int_detect_in, 2))
    else $error("flag rose without input edge");
  a_flag_fall: assert property ($fell(int_flag) |-> $past(ex) || $past(ex, 2))
    else $error("flag fell without execute");
  cover property (ex ##2 general_pin_zero_oe);
  cover property ($rose(int_flag));
  cover property (reg_rd && reg_addr == RSU_OFS_RESP);
endmodule : rsu_settings_monitor
bind rsu_settings rsu_settings_monitor rsu_settings_monitor_i (.core_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_ref, .int_detect_in,
  .int_flag, .general_pin_zero_in, .general_pin_zero_out, .general_pin_zero_oe,
  .suspend_indicator, .uart_receive_led);
`default_nettype wire

// File: sim/rsu_host.sv
// rsu_host: host model writing command bytes over the register port.
// assumes the slave never stalls and read data stand one cycle.
`timescale 1ns/100ps
`default_nettype none
module rsu_host (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  import rsu_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released lines invert so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // data stand from this edge to the next; take them mid-cycle, clear of the edges
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd
  // bytes 1..4 untouched; two edges let settings land
  task automatic cmd(input logic [7:0] c, b5, b6, b7, b8);
    wr(8'h00, {24'h0, c});
    wr(8'h14, {24'h0, b5});
    wr(8'h18, {24'h0, b6});
    wr(8'h1C, {24'h0, b7});
    wr(8'h20, {24'h0, b8});
    wr(RSU_OFS_EXEC, 32'h0);
    repeat (2) @(posedge core_clk);
  endtask : cmd
endmodule : rsu_host
`default_nettype wire

// File: sim/tb.sv
// tb: self-checking bench for rsu_settings driven by the host model.
// assumes a 200 MHz core_clk and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rsu_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  rsu_adc_ref_t adc_ref;
  logic int_detect_in = 1'b0;
  logic int_flag;
  logic general_pin_zero_in = 1'b0;
  logic general_pin_zero_out;
  logic general_pin_zero_oe;
  logic suspend_indicator = 1'b0;
  logic uart_receive_led = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] d;
  always #2.5 core_clk = ~core_clk;
  rsu_settings rsu_settings_i (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .adc_ref, .int_detect_in, .int_flag, .general_pin_zero_in,
    .general_pin_zero_out, .general_pin_zero_oe, .suspend_indicator, .uart_receive_led);
  rsu_host rsu_host_i (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic det(input logic v, input logic e);
    @(posedge core_clk);
    int_detect_in <= v;
    repeat (3) @(posedge core_clk);
    chk(32'(int_flag), 32'(e));
  endtask : det
  task automatic ind(input logic s, input logic l, input logic e);
    @(posedge core_clk);
    suspend_indicator <= s;
    uart_receive_led <= l;
    @(negedge core_clk);
    chk(32'({general_pin_zero_oe, general_pin_zero_out}), 32'({1'b1, e}));
  endtask : ind
  function automatic logic [31:0] pin();
    return 32'({general_pin_zero_oe, general_pin_zero_out});
  endfunction : pin
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rsu_host_i.rd(RSU_OFS_STATUS, d);
    chk(d, 32'h200);
    chk(32'({adc_ref, int_flag, general_pin_zero_oe}), 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_adc();
    for (int i = 0; i < 8; i++) begin
      rsu_host_i.cmd(RSU_CMD_CODE, 8'hF8 | 8'(i), 8'h00, 8'h00, 8'h00);
      chk(32'(adc_ref), 32'(i));
    end
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h7A, 8'h00, 8'h00, 8'h00);
    chk(32'(adc_ref), 32'h7);
    $display("t_adc done");
  endtask : t_adc
  task automatic t_edge();
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h98, 8'h00, 8'h00);
    det(1'b1, 1'b1);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h01, 8'h00, 8'h00);
    chk(32'(int_flag), 32'h1);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h81, 8'h00, 8'h00);
    chk(32'(int_flag), 32'h0);
    det(1'b0, 1'b0);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h96, 8'h00, 8'h00);
    det(1'b1, 1'b0);
    det(1'b0, 1'b1);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h8D, 8'h00, 8'h00);
    chk(32'(int_flag), 32'h0);
    det(1'b1, 1'b0);
    det(1'b0, 1'b0);
    $display("t_edge done");
  endtask : t_edge
  task automatic t_pin();
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h80, 8'h10);
    chk(pin(), 32'h3);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h80, 8'hE0);
    chk(pin(), 32'h2);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h00, 8'h08);
    chk(pin(), 32'h2);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h80, 8'h08);
    chk(32'(general_pin_zero_oe), 32'h0);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h80, 8'h09);
    ind(1'b1, 1'b0, 1'b1);
    ind(1'b0, 1'b1, 1'b0);
    rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h80, 8'h1A);
    ind(1'b0, 1'b1, 1'b1);
    for (int f = 3; f < 8; f++) begin
      rsu_host_i.cmd(RSU_CMD_CODE, 8'h00, 8'h00, 8'h80, 8'(f));
      ind(1'b1, 1'b0, 1'b0);
    end
    @(posedge core_clk);
    general_pin_zero_in <= 1'b1;
    rsu_host_i.rd(RSU_OFS_STATUS, d);
    chk(32'(d[8:6]), 32'(RSU_FN_RX_LED));
    chk(32'(d[11]), 32'h1);
    $display("t_pin done");
  endtask : t_pin
  task automatic t_code();
    rsu_host_i.rd(RSU_OFS_RESP, d);
    chk(d, {15'h0, 1'b1, RSU_RESP_OK, RSU_CMD_CODE});
    rsu_host_i.rd(RSU_OFS_RESP, d);
    chk(d, {16'h0, RSU_RESP_OK, RSU_CMD_CODE});
    rsu_host_i.cmd(8'h61, 8'h80, 8'h81, 8'h80, 8'h10);
    chk(32'({adc_ref, general_pin_zero_oe, general_pin_zero_out}), 32'h1E);
    rsu_host_i.rd(RSU_OFS_RESP, d);
    chk(d, {16'h0, RSU_RESP_OK, RSU_CMD_CODE});
    rsu_host_i.rd(8'h30, d);
    chk(d, 32'h0);
    $display("t_code done");
  endtask : t_code
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_adc();
    t_edge();
    t_pin();
    t_code();
    summarize();
  end
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule : tb
`default_nettype wire
